// ### src/fcp_core.sv
// Four-channel PWM core with one shared down counter and Wishbone registers
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
module fcp_core
    import fcp_pkg::*;
#(
    parameter int PRESC_W = 8
) (
    // Clock and reset
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    // Wishbone slave
    input  wire fcp_wb_req_type wb_req,
    output logic                wb_ack,
    output logic [31:0]         wb_dat,
    // Interrupt
    output logic                irq,
    // Channel pins
    output logic                channel0_output,
    output logic                channel1_output,
    output logic                channel2_output,
    output logic                channel3_output
);

    // Prescaler register is eight bits wide, the divider cannot be wider
    if (PRESC_W < 1 || PRESC_W > 8) begin : g_chk
        $error("PRESC_W must lie between 1 and 8");
    end

    logic                 ack_q;
    logic [31:0]          dat_q;
    logic                 acc;
    logic                 wr;
    logic [7:0]           idx;
    logic [7:0]           wdat;
    logic [7:0]           rd_d;
    logic                 wr_ctrl;
    logic [CNT_W-1:0]     per_buf_q;
    logic [CNT_W-1:0]     per_work_q;
    logic [CNT_W-1:0]     duty_buf_q  [CH_NUM];
    logic [CNT_W-1:0]     duty_work_q [CH_NUM];
    fcp_ctrl_type         ctrl_q;
    logic                 run_q;
    logic                 load_q;
    logic                 flag_q;
    logic                 clear_q;
    logic [CH_NUM-1:0]    inv_q;
    logic [PRESC_W-1:0]   psc_q;
    logic [PRESC_W-1:0]   psc_cnt_q;
    logic [CNT_W-1:0]     cnt_q;
    logic                 tick;
    logic                 unf;
    logic                 xfer;
    logic [CH_NUM-1:0]    out_q;
    logic [CH_NUM-1:0]    latch_q;
    logic [CH_NUM-1:0]    pin_q;
    logic                 sts_q;
    logic                 ien_q;
    logic                 irq_q;

    // Bus decode: a request is taken once, in the cycle before ack
    assign acc     = wb_req.cyc & wb_req.stb & ~ack_q;
    assign wr      = acc & wb_req.we & wb_req.sel[0];
    assign idx     = wb_req.adr[9:2];
    assign wdat    = wb_req.dat[7:0];
    assign wr_ctrl = wr & (idx == IDX_CTRL);

    // Control view: every field has its own flop, so each has one driver
    assign ctrl_q  = {run_q, load_q, flag_q, clear_q, inv_q};

    // Counter timing events; ticking at or past the divider means a
    // lowered divider never waits for the prescale counter to wrap
    assign tick = ctrl_q.run & ~ctrl_q.clear & (psc_cnt_q >= psc_q); // RULE_04
    assign unf  = tick & (cnt_q == COUNT_CLEARED);                   // RULE_05
    assign xfer = unf & ctrl_q.load;                                 // RULE_12

    // Bus answer one cycle after the request, unmapped reads give zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= acc;
            dat_q <= (acc & ~wb_req.we) ? {24'h00_0000, rd_d} : 32'h0000_0000;
        end
    end

    // Read multiplexer over every mapped register except the write-only interrupt clear
    always_comb begin
        rd_d = 8'h00;
        if (idx == IDX_PERIOD_LOW) begin
            rd_d = per_buf_q[7:0];
        end
        if (idx == IDX_PERIOD_HIGH) begin
            rd_d = {6'h00, per_buf_q[9:8]}; // RULE_17
        end
        for (int i = 0; i < CH_NUM; i++) begin
            if (idx == IDX_DUTY_LOW[i]) begin
                rd_d = duty_buf_q[i][7:0];
            end
            if (idx == IDX_DUTY_HIGH[i]) begin
                rd_d = {6'h00, duty_buf_q[i][9:8]}; // RULE_17
            end
        end
        if (idx == IDX_CTRL) begin
            rd_d = ctrl_q;
        end
        if (idx == IDX_PRESCALE) begin
            rd_d = 8'(psc_q);
        end
        if (idx == IDX_IRQ_STATUS) begin
            rd_d = {7'h00, sts_q};
        end
        if (idx == IDX_IRQ_ENABLE) begin
            rd_d = {7'h00, ien_q};
        end
        if (idx == IDX_PORT_LATCH) begin
            rd_d = {4'h0, latch_q};
        end
    end

    // Holding registers take writes at any time without disturbing output
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            per_buf_q <= VALUE_RESET;
            for (int i = 0; i < CH_NUM; i++) begin
                duty_buf_q[i] <= VALUE_RESET;
            end
        end else begin
            if (wr && idx == IDX_PERIOD_LOW) begin
                per_buf_q[7:0] <= wdat; // RULE_06
            end
            if (wr && idx == IDX_PERIOD_HIGH) begin
                per_buf_q[9:8] <= wdat[HIGH_BITS_W-1:0]; // RULE_06
            end
            for (int i = 0; i < CH_NUM; i++) begin
                if (wr && idx == IDX_DUTY_LOW[i]) begin
                    duty_buf_q[i][7:0] <= wdat; // RULE_08
                end
                if (wr && idx == IDX_DUTY_HIGH[i]) begin
                    duty_buf_q[i][9:8] <= wdat[HIGH_BITS_W-1:0]; // RULE_08
                end
            end
        end
    end

    // Working copies change only at an underflow with load pending
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            per_work_q <= VALUE_RESET;
            for (int i = 0; i < CH_NUM; i++) begin
                duty_work_q[i] <= VALUE_RESET;
            end
        end else if (xfer) begin
            per_work_q <= per_buf_q; // RULE_12
            for (int i = 0; i < CH_NUM; i++) begin
                duty_work_q[i] <= duty_buf_q[i]; // RULE_12
            end
        end
    end

    // Run and invert bits follow software; clear is a one-cycle pulse
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            run_q   <= CTRL_RESET[CTRL_RUN_BIT];
            clear_q <= CTRL_RESET[CTRL_CLEAR_BIT];
            inv_q   <= CTRL_RESET[CH_NUM-1:0];
        end else begin
            clear_q <= wr_ctrl & wdat[CTRL_CLEAR_BIT]; // RULE_09
            if (wr_ctrl) begin
                run_q <= wdat[CTRL_RUN_BIT]; // RULE_10
                inv_q <= wdat[CH_NUM-1:0];   // RULE_15
            end
        end
    end

    // Load bit: a write in the transfer cycle wins over the auto-clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            load_q <= CTRL_RESET[CTRL_LOAD_BIT];
        end else if (wr_ctrl) begin
            load_q <= wdat[CTRL_LOAD_BIT];
        end else if (xfer) begin
            load_q <= 1'b0; // RULE_13
        end
    end

    // Underflow flag: hardware set wins over a software clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flag_q <= CTRL_RESET[CTRL_FLAG_BIT];
        end else if (unf) begin
            flag_q <= 1'b1; // RULE_16
        end else if (wr_ctrl) begin
            flag_q <= wdat[CTRL_FLAG_BIT];
        end
    end

    // Prescaler setting, divide by value plus one
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            psc_q <= PRESCALE_RESET[PRESC_W-1:0];
        end else if (wr && idx == IDX_PRESCALE) begin
            psc_q <= wdat[PRESC_W-1:0];
        end
    end

    // Prescale counter restarts whenever the core stops or is cleared
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            psc_cnt_q <= '0;
        end else if (!ctrl_q.run || ctrl_q.clear || tick) begin
            psc_cnt_q <= '0;
        end else begin
            psc_cnt_q <= psc_cnt_q + 1'b1; // RULE_04
        end
    end

    // Shared down counter; period+1 counts per cycle sets the rate
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q <= COUNT_CLEARED;
        end else if (ctrl_q.clear) begin
            cnt_q <= COUNT_CLEARED; // RULE_09
        end else if (unf) begin
            // Reload takes the new period in the same cycle as the transfer
            cnt_q <= ctrl_q.load ? per_buf_q : per_work_q; // RULE_05 RULE_07
        end else if (tick) begin
            cnt_q <= cnt_q - 1'b1; // RULE_04
        end
    end

    // Compare stage; outputs freeze at their last level when halted
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            out_q <= OUT_RESET; // RULE_02
        end else if (ctrl_q.run) begin
            for (int i = 0; i < CH_NUM; i++) begin
                // All ones is low even when the period is also all ones
                out_q[i] <= (duty_work_q[i] != DUTY_ALL_ONES) && // RULE_14
                            (cnt_q >= duty_work_q[i]);     // RULE_11 RULE_07
            end
        end
    end

    // Port latch register gating each pin
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            latch_q <= LATCH_RESET;
        end else if (wr && idx == IDX_PORT_LATCH) begin
            latch_q <= wdat[CH_NUM-1:0];
        end
    end

    // Pins: a cleared latch pulls the pin low like a wired-AND port
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_q <= PIN_RESET;
        end else begin
            pin_q <= latch_q & (out_q ^ ctrl_q.inv); // RULE_03 RULE_15 RULE_01
        end
    end

    // Transfer-done status, set wins over clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sts_q <= 1'b0;
        end else if (xfer) begin
            sts_q <= 1'b1;
        end else if (wr && idx == IDX_IRQ_CLEAR && wdat[IRQ_XFER_BIT]) begin
            sts_q <= 1'b0;
        end
    end

    // Interrupt enable and level output
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ien_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            irq_q <= sts_q & ien_q;
            if (wr && idx == IDX_IRQ_ENABLE) begin
                ien_q <= wdat[IRQ_XFER_BIT];
            end
        end
    end

    // Outputs straight from flip-flops
    assign wb_ack          = ack_q;
    assign wb_dat          = dat_q;
    assign irq             = irq_q;
    assign channel0_output = pin_q[0];
    assign channel1_output = pin_q[1];
    assign channel2_output = pin_q[2];
    assign channel3_output = pin_q[3];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Outputs start high when reset lifts
    a_reset_out_high: assert property ( // RULE_02
        $rose(rst_n) |-> out_q == OUT_RESET)
        else $error("channel outputs not high after reset");

    // Counting steps down by one per prescaled tick
    a_count_down_step: assert property ( // RULE_04
        tick && cnt_q != COUNT_CLEARED |=> cnt_q == $past(cnt_q) - 10'h001)
        else $error("counter did not step down by one");

    // Underflow reloads the right period
    a_unf_reload: assert property ( // RULE_05
        unf && ctrl_q.load |=> cnt_q == $past(per_buf_q))
        else $error("underflow did not reload the new period");

    // Clear forces zero and stops prescaling for that cycle
    a_clear_zero: assert property ( // RULE_09
        ctrl_q.clear |=> cnt_q == COUNT_CLEARED && psc_cnt_q == '0)
        else $error("clear did not zero the counter");

    // Counter holds while not running
    a_halt_holds: assert property ( // RULE_10
        !ctrl_q.run && !ctrl_q.clear |=> $stable(cnt_q))
        else $error("counter moved while halted");

    // Working period and channel 0 duty change only through a transfer
    a_buffer_only_xfer: assert property ( // RULE_12
        !xfer |=> $stable(per_work_q) && $stable(duty_work_q[0]))
        else $error("working value changed without transfer");

    // Load clears itself after a transfer
    a_load_autoclr: assert property ( // RULE_13
        xfer && !wr_ctrl |=> !ctrl_q.load && per_work_q == $past(per_buf_q))
        else $error("load bit not cleared after transfer");

    // Duty zero gives a high output after two cycles running
    a_duty_zero_high: assert property ( // RULE_14
        (ctrl_q.run && duty_work_q[0] == VALUE_RESET)[*2] |-> out_q[0])
        else $error("duty zero did not hold output high");

    // Duty above the current count range gives a low output
    a_duty_over_low: assert property ( // RULE_14
        ctrl_q.run && duty_work_q[2] > per_work_q && cnt_q <= per_work_q
        |=> !out_q[2])
        else $error("duty above period did not hold output low");

    // Output low while count below duty
    a_out_below_low: assert property ( // RULE_11
        ctrl_q.run && cnt_q < duty_work_q[1] |=> !out_q[1])
        else $error("output not low below duty");

    // Prescale counter past a lowered divider restarts at once
    a_psc_no_wrap: assert property ( // RULE_04
        psc_cnt_q > psc_q |=> psc_cnt_q == '0)
        else $error("prescale counter ran past its divider");

    // Inverted pin follows the complement one cycle on
    a_pin_invert: assert property ( // RULE_15
        latch_q[3] && ctrl_q.inv[3] |=> pin_q[3] == !$past(out_q[3]))
        else $error("inverted pin does not complement output");

    // Cleared latch keeps the pin low
    a_latch_gate: assert property ( // RULE_03
        !latch_q[1] |=> !pin_q[1])
        else $error("pin driven while latch bit is zero");

    // Underflow flag is set and the interrupt ignores it
    a_flag_no_irq: assert property ( // RULE_16
        unf && !xfer && !sts_q |=> ctrl_q.flag ##1 !irq_q)
        else $error("underflow flag missing or raised interrupt");

    // Reserved high bits read zero
    a_rsv_read_zero: assert property ( // RULE_17
        acc && !wb_req.we && idx == IDX_DUTY_HIGH[3]
        |=> wb_ack && wb_dat[31:2] == 30'h0)
        else $error("reserved high bits read nonzero");

endmodule

// ### src/fcp_pkg.sv
// Constants, register map and carrier types of the four-channel PWM core
// Function
// RULE_01: Four independent PWM channels, each with its own output pin.
// RULE_02: Every channel's internal output is high after reset.
// RULE_03: Software writes a one to each port latch bit before the pin follows.
// RULE_04: One shared 10-bit down counter, clocked by a prescaled system clock.
// RULE_05: On underflow the counter reloads from the period value and repeats.
// RULE_06: Period is 10 bits: low byte register plus bits 9:8 in high register.
// RULE_07: Frequency is counter clock over period+1; duty is duty over period+1.
// RULE_08: Each channel duty is 10 bits split over low and high registers.
// RULE_09: Setting the clear bit forces the down counter to a defined value.
// RULE_10: Program period and duty first; setting the run bit starts counting.
// RULE_11: Output high until count falls below duty, then low until underflow.
// RULE_12: Period and duty are double buffered; load plus underflow applies them.
// RULE_13: After the transfer the load bit clears itself by the next cycle.
// RULE_14: Duty zero holds output high; all ones or above period holds it low.
// RULE_15: Each channel has an invert bit that complements its pin waveform.
// RULE_16: Each underflow sets an underflow flag that raises no interrupt.
// RULE_17: Reserved bits 7:2 of every high register read zero, writes ignored.
package fcp_pkg;

    localparam int CH_NUM = 4;
    localparam int CNT_W  = 10;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_PERIOD_HIGH = 8'hd1;
    localparam logic [7:0] IDX_PERIOD_LOW  = 8'hd9;
    localparam logic [7:0] IDX_DUTY_HIGH [CH_NUM] = '{8'hd2, 8'hd3, 8'hd5, 8'hd6};
    localparam logic [7:0] IDX_DUTY_LOW  [CH_NUM] = '{8'hda, 8'hdb, 8'hdd, 8'hde};
    localparam logic [7:0] IDX_CTRL        = 8'hdc;
    localparam logic [7:0] IDX_PRESCALE    = 8'he0;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'he1;
    localparam logic [7:0] IDX_IRQ_CLEAR   = 8'he2;
    localparam logic [7:0] IDX_IRQ_ENABLE  = 8'he3;
    localparam logic [7:0] IDX_PORT_LATCH  = 8'he4;

    // Field positions of the main control register, high register width and interrupt bit
    localparam int CTRL_RUN_BIT   = 7;
    localparam int CTRL_LOAD_BIT  = 6;
    localparam int CTRL_FLAG_BIT  = 5;
    localparam int CTRL_CLEAR_BIT = 4;
    localparam int HIGH_BITS_W    = 2;
    localparam int IRQ_XFER_BIT   = 0;

    // Reset values and special codes
    localparam logic [7:0]        CTRL_RESET     = 8'h00;
    localparam logic [7:0]        PRESCALE_RESET = 8'h00;
    localparam logic [CNT_W-1:0]  VALUE_RESET    = 10'h000;
    localparam logic [CNT_W-1:0]  COUNT_CLEARED  = 10'h000;
    localparam logic [CNT_W-1:0]  DUTY_ALL_ONES  = 10'h3ff;
    localparam logic [CH_NUM-1:0] OUT_RESET      = 4'hf;
    localparam logic [CH_NUM-1:0] LATCH_RESET    = 4'h0;
    localparam logic [CH_NUM-1:0] PIN_RESET      = 4'h0;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [9:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } fcp_wb_req_type;

    // Main control register layout
    typedef struct packed {
        logic              run;
        logic              load;
        logic              flag;
        logic              clear;
        logic [CH_NUM-1:0] inv;
    } fcp_ctrl_type;

endpackage

// ### tb/fcp_load_model.sv
// Load model that watches the four channel pins and tallies activity
`timescale 1ns/100ps
module fcp_load_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Pins and window control
    input  wire logic [3:0]  pins,
    input  wire logic        clr,
    // Tallies per channel
    output logic [3:0][15:0] high_cnt,
    output logic [3:0][15:0] rise_cnt
);
    logic [3:0] prev_q;

    // Each pin feeds its own load, so every channel is tallied apart
    always_ff @(posedge ref_clk) begin
        prev_q <= pins;
        for (int i = 0; i < 4; i++) begin
            if (!rst_n || clr) begin
                high_cnt[i] <= 16'h0000;
                rise_cnt[i] <= 16'h0000;
            end else begin
                high_cnt[i] <= high_cnt[i] + 16'(pins[i]);
                rise_cnt[i] <= rise_cnt[i] + 16'(pins[i] & ~prev_q[i]);
            end
        end
    end
endmodule

// ### tb/four_channel_pwm_core_tb.sv
// Self-checking bench for the four-channel PWM core
`timescale 1ns/100ps
module four_channel_pwm_core_tb import fcp_pkg::*;;
    logic             ref_clk = 1'b0;
    logic             rst_n = 1'b0;
    fcp_wb_req_type   wb_req = '0;
    logic             wb_ack;
    logic [31:0]      wb_dat;
    logic             irq;
    logic [3:0]       pins;
    logic             clr = 1'b0;
    logic [3:0][15:0] high_cnt;
    logic [3:0][15:0] rise_cnt;
    logic [7:0]       rd;
    int               fail_count = 0;
    int               num_checks = 0;

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    fcp_core dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req),
        .wb_ack(wb_ack), .wb_dat(wb_dat), .irq(irq),
        .channel0_output(pins[0]), .channel1_output(pins[1]),
        .channel2_output(pins[2]), .channel3_output(pins[3]));

    fcp_load_model load_u (.ref_clk(ref_clk), .rst_n(rst_n), .pins(pins),
        .clr(clr), .high_cnt(high_cnt), .rise_cnt(rise_cnt));

    task automatic chk(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic xfer(input logic [7:0] idx, input logic we,
                        input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'h1, {24'h0, wd}};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 40);
        rd = wb_dat[7:0];
        if (n >= 40) chk("ack wait", 32'h0, 32'h1);
        wb_req <= '0;
    endtask

    task automatic rc(input string what, input logic [7:0] idx, exp);
        xfer(idx, 1'b0, 8'h00);
        chk(what, {24'h0, rd}, {24'h0, exp});
    endtask

    task automatic set_val(input logic [7:0] lo, hi, input logic [9:0] v);
        xfer(lo, 1'b1, v[7:0]);
        xfer(hi, 1'b1, {6'h00, v[9:8]});
    endtask

    // Counts cover exactly n samples after the clear
    task automatic measure(input int n);
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Polling bounded, since a stuck load bit would hang the run
    task automatic wait_load();
        int n;
        n = 0;
        do begin
            xfer(IDX_CTRL, 1'b0, 8'h00);
            n++;
        end while (rd[CTRL_LOAD_BIT] !== 1'b0 && n < 20);
        chk("load clear", {31'h0, rd[CTRL_LOAD_BIT]}, 32'h0);
    endtask

    task automatic t_reset();
        rc("period low", IDX_PERIOD_LOW, 8'h00);
        rc("period high", IDX_PERIOD_HIGH, 8'h00);
        for (int i = 0; i < CH_NUM; i++) begin
            rc("duty low", IDX_DUTY_LOW[i], 8'h00);
            rc("duty high", IDX_DUTY_HIGH[i], 8'h00);
        end
        rc("control", IDX_CTRL, CTRL_RESET);
        xfer(IDX_PERIOD_HIGH, 1'b1, 8'hff);
        rc("period high bits", IDX_PERIOD_HIGH, 8'h03);
        for (int i = 0; i < CH_NUM; i++) begin
            xfer(IDX_DUTY_HIGH[i], 1'b1, 8'hfe);
            rc("duty high bits", IDX_DUTY_HIGH[i], 8'h02);
        end
        xfer(8'h10, 1'b1, 8'h5a);
        rc("unmapped", 8'h10, 8'h00);
    endtask

    // Idle outputs sit high, visible once latches hold ones
    task automatic t_latch();
        xfer(IDX_PORT_LATCH, 1'b1, 8'h0f);
        repeat (3) @(posedge ref_clk);
        chk("idle pins", {28'h0, pins}, 32'hf);
    endtask

    task automatic t_run();
        xfer(IDX_CTRL, 1'b1, 8'h10);
        rc("clear pulse", IDX_CTRL, 8'h00);
        set_val(IDX_PERIOD_LOW, IDX_PERIOD_HIGH, 10'h009);
        set_val(IDX_DUTY_LOW[0], IDX_DUTY_HIGH[0], 10'h000);
        set_val(IDX_DUTY_LOW[1], IDX_DUTY_HIGH[1], 10'h003);
        set_val(IDX_DUTY_LOW[2], IDX_DUTY_HIGH[2], 10'h3ff);
        set_val(IDX_DUTY_LOW[3], IDX_DUTY_HIGH[3], 10'h00c);
        xfer(IDX_CTRL, 1'b1, 8'hc0);
        wait_load();
        measure(100);
        chk("high ch0", {16'h0, high_cnt[0]}, 32'd100);
        chk("high ch1", {16'h0, high_cnt[1]}, 32'd70);
        chk("rise ch1", {16'h0, rise_cnt[1]}, 32'd10);
        chk("high ch2", {16'h0, high_cnt[2]}, 32'd0);
        chk("high ch3", {16'h0, high_cnt[3]}, 32'd0);
        xfer(IDX_PRESCALE, 1'b1, 8'h01);
        repeat (40) @(posedge ref_clk);
        measure(200);
        chk("slow high ch1", {16'h0, high_cnt[1]}, 32'd140);
        chk("slow rise ch1", {16'h0, rise_cnt[1]}, 32'd10);
        xfer(IDX_PRESCALE, 1'b1, 8'h00);
        xfer(IDX_CTRL, 1'b1, 8'h82);
        repeat (20) @(posedge ref_clk);
        measure(100);
        chk("inverted ch1", {16'h0, high_cnt[1]}, 32'd30);
        xfer(IDX_CTRL, 1'b1, 8'h80);
        repeat (20) @(posedge ref_clk);
        rc("underflow flag", IDX_CTRL, 8'ha0);
    endtask

    // New duty held back until load; transfer raises the interrupt
    task automatic t_buffer_irq();
        xfer(IDX_IRQ_ENABLE, 1'b1, 8'h01);
        xfer(IDX_IRQ_CLEAR, 1'b1, 8'h01);
        set_val(IDX_DUTY_LOW[1], IDX_DUTY_HIGH[1], 10'h005);
        measure(100);
        chk("old duty ch1", {16'h0, high_cnt[1]}, 32'd70);
        chk("no underflow irq", {31'h0, irq}, 32'h0);
        xfer(IDX_CTRL, 1'b1, 8'hc0);
        wait_load();
        rc("xfer status", IDX_IRQ_STATUS, 8'h01);
        chk("irq set", {31'h0, irq}, 32'h1);
        measure(100);
        chk("new duty ch1", {16'h0, high_cnt[1]}, 32'd50);
        xfer(IDX_IRQ_CLEAR, 1'b1, 8'h01);
        repeat (2) @(posedge ref_clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        xfer(IDX_IRQ_ENABLE, 1'b1, 8'h00);
        xfer(IDX_CTRL, 1'b1, 8'hc0);
        wait_load();
        rc("masked status", IDX_IRQ_STATUS, 8'h01);
        chk("irq masked", {31'h0, irq}, 32'h0);
        xfer(IDX_IRQ_CLEAR, 1'b1, 8'h01);
        repeat (30) @(posedge ref_clk);
        rc("status after clear", IDX_IRQ_STATUS, 8'h00);
        chk("irq after underflows", {31'h0, irq}, 32'h0);
    endtask

    // Clearing run freezes the outputs
    task automatic t_stop();
        xfer(IDX_CTRL, 1'b1, 8'h00);
        measure(100);
        chk("stopped ch1", {16'h0, rise_cnt[1]}, 32'd0);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (15) @(posedge ref_clk);
        #1;
        chk("pins in reset", {28'h0, pins}, {28'h0, PIN_RESET});
        @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_latch();
        t_run();
        t_buffer_irq();
        t_stop();
        report_and_stop();
    end

    // Sequence needs about a thousand cycles; ample margin before giving up
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule
